// ---- pkg/tcsc_map.vh ----
// Register map, field positions and reset values of the timer compare
// status and control block. Assumes a 4-bit word address on the plain port.
// Notes on behaviour
// - Triggered mode, reinit set: second trigger reloads, continues
// - Triggered mode, reinit clear: second trigger pauses, third resumes
// - Quadrature mode: direction bit 1 up, 0 down
// - Direction invert control inverts the direction bit
// - Bit 8 reads zero, writes ignored
// - Interrupt when match two flag and enable set
// - Interrupt when match one flag and enable set
// - Match two flag sticky until zero written
// - Match one flag sticky until zero written
// - Second preload select: never, match one, match two
// - First preload select: never, match one, match two
// - Second preload value is read/write storage
`ifndef TCSC_MAP_VH
`define TCSC_MAP_VH

// Word offsets on the register port
`define TCSC_OFF_CMP1       4'h0
`define TCSC_OFF_CMP2       4'h1
`define TCSC_OFF_PLD1       4'h2
`define TCSC_OFF_PLD2       4'h3
`define TCSC_OFF_MODE       4'h4
`define TCSC_OFF_COUNT      4'h5
`define TCSC_OFF_EVT_STAT   4'h6
`define TCSC_OFF_EVT_MASK   4'h7
`define TCSC_OFF_LOAD       4'h8
`define TCSC_OFF_CSCTRL     4'hA

// Compare status and control field positions
`define TCSC_BIT_REINIT     10
`define TCSC_BIT_UP         9
`define TCSC_BIT_RSVD       8
`define TCSC_BIT_M2_EN      7
`define TCSC_BIT_M1_EN      6
`define TCSC_BIT_M2_FLAG    5
`define TCSC_BIT_M1_FLAG    4
`define TCSC_SEL2_HI        3
`define TCSC_SEL2_LO        2
`define TCSC_SEL1_HI        1
`define TCSC_SEL1_LO        0

// Mode register fields
`define TCSC_MODE_HI        2
`define TCSC_MODE_LO        0
`define TCSC_BIT_DIR_INV    3

// Count mode codes
`define TCSC_CM_OFF         3'b000
`define TCSC_CM_QUAD        3'b100
`define TCSC_CM_TRIG        3'b110

// Preload select codes
`define TCSC_SEL_NEVER      2'b00
`define TCSC_SEL_ON_M1      2'b01
`define TCSC_SEL_ON_M2      2'b10

// Event status bits
`define TCSC_EVT_M1         0
`define TCSC_EVT_M2         1
`define TCSC_EVT_RELOAD     2
`define TCSC_EVT_PAUSE      3

// Reset values
`define TCSC_RST_WORD       16'h0000
`define TCSC_RST_EVT        4'h0
`define TCSC_RST_MODE       3'b000

`endif

// ---- hdl/tcsc_cmp_slot.v ----
// One compare register with its preload register.
// Assumes writes and copy strobes are on mclk_i and one cycle long.
`timescale 1ns/10ps
`include "tcsc_map.vh"

module tcsc_cmp_slot #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // Software writes
  input  wire [WIDTH-1:0] wdata_i,
  input  wire             cmp_we_i,
  input  wire             pld_we_i,
  // Copy preload into compare
  input  wire             copy_i,
  // Stored values
  output reg  [WIDTH-1:0] cmp_o,
  output reg  [WIDTH-1:0] pld_o
);

  // Compare value; a software write wins over a copy in the same cycle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      cmp_o <= `TCSC_RST_WORD;
    end else if (cmp_we_i) begin
      cmp_o <= wdata_i;
    end else if (copy_i) begin
      cmp_o <= pld_o;
    end
  end

  // Preload value, plain read/write storage
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pld_o <= `TCSC_RST_WORD;
    end else if (pld_we_i) begin
      pld_o <= wdata_i;
    end
  end

endmodule // tcsc_cmp_slot

// ---- hdl/tcsc_top.v ----
// Compare status and control of one timer channel with a minimal counter,
// two compare/preload slots, triggered and quadrature handling.
// Assumes count pulses and triggers come from logic on mclk_i, one cycle long.
`timescale 1ns/10ps
`include "tcsc_map.vh"

module tcsc_top #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             mclk_i,
  input  wire             rst_i,
  // Register port
  input  wire [3:0]       addr_i,
  input  wire [WIDTH-1:0] wdata_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output reg  [WIDTH-1:0] rdata_o,
  // Channel events
  input  wire             cnt_up_i,
  input  wire             cnt_dn_i,
  input  wire             trig_i,
  // Channel results
  output reg  [WIDTH-1:0] count_o,
  output reg              match_one_o,
  output reg              match_two_o,
  output reg              irq_o
);

  // Triggered count states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  // Preload select decode, used by both slots
  function sel_hit;
    input [1:0] sel;
    input       m1;
    input       m2;
    begin
      sel_hit = ((sel == `TCSC_SEL_ON_M1) & m1) | ((sel == `TCSC_SEL_ON_M2) & m2);
    end
  endfunction

  // Control and status state
  reg [2:0]       mode_r;
  reg             dir_inv_r;
  reg             reinit_r;
  reg             m1_en_r;
  reg             m2_en_r;
  reg             m1_flag_r;
  reg             m2_flag_r;
  reg [1:0]       sel1_r;
  reg [1:0]       sel2_r;
  reg             up_last_r;
  reg [WIDTH-1:0] load_r;
  reg [3:0]       evt_stat_r;
  reg [3:0]       evt_mask_r;
  reg [2:0]       state_r;
  reg [2:0]       state_nxt;

  // Combinational results
  reg [WIDTH-1:0] count_nxt;
  reg             step;
  reg             reload;
  reg             pause;
  reg [WIDTH-1:0] rd_val;

  wire            wr_cs;
  wire            wr_mode;
  wire            wr_load;
  wire            wr_mask;
  wire            rd_stat;
  wire            quad_mode;
  wire            trig_mode;
  wire            running;
  wire            m1_hit;
  wire            m2_hit;
  wire [1:0]      cmp_we;
  wire [1:0]      pld_we;
  wire [1:0]      copy;
  wire [WIDTH-1:0] cmp_w [0:1];
  wire [WIDTH-1:0] pld_w [0:1];
  wire [3:0]      evt_set;
  wire [WIDTH-1:0] cs_word;

  // Address decode for writes and the clearing read
  assign wr_cs   = wr_i && (addr_i == `TCSC_OFF_CSCTRL);
  assign wr_mode = wr_i && (addr_i == `TCSC_OFF_MODE);
  assign wr_load = wr_i && (addr_i == `TCSC_OFF_LOAD);
  assign wr_mask = wr_i && (addr_i == `TCSC_OFF_EVT_MASK);
  assign rd_stat = rd_i && (addr_i == `TCSC_OFF_EVT_STAT);

  assign cmp_we[0] = wr_i && (addr_i == `TCSC_OFF_CMP1);
  assign cmp_we[1] = wr_i && (addr_i == `TCSC_OFF_CMP2);
  assign pld_we[0] = wr_i && (addr_i == `TCSC_OFF_PLD1);
  assign pld_we[1] = wr_i && (addr_i == `TCSC_OFF_PLD2);

  assign quad_mode = (mode_r == `TCSC_CM_QUAD);
  assign trig_mode = (mode_r == `TCSC_CM_TRIG);

  // Counting is only allowed in a live state; triggered mode needs a start
  assign running = (mode_r != `TCSC_CM_OFF) && (!trig_mode || (state_r == ST_RUN));

  // Retrigger decode, kept apart from the sequencer: the sequencer reads the
  // match path, which itself depends on the reload, so one process for both
  // would close a combinational loop
  always @* begin
    reload = 1'b0;
    pause  = 1'b0;
    if (trig_mode && (state_r == ST_RUN) && trig_i) begin
      if (reinit_r) begin
        reload = 1'b1;
      end else begin
        pause  = 1'b1;
      end
    end
  end

  // Triggered count sequencing
  always @* begin
    state_nxt = state_r;
    if (!trig_mode) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig_i) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          // A retrigger with reinit set reloads and stays in RUN
          if (trig_i && reinit_r) begin
            state_nxt = ST_RUN;
          end else if (trig_i) begin
            state_nxt = ST_HOLD;
          end else if (m1_hit) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (trig_i) begin
            state_nxt = ST_RUN;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Next count; up and down together cancel, a reload overrides a step
  always @* begin
    count_nxt = count_o;
    step      = 1'b0;
    if (reload) begin
      count_nxt = load_r;
    end else if (running && (cnt_up_i ^ cnt_dn_i)) begin
      step = 1'b1;
      if (cnt_up_i) begin
        count_nxt = count_o + {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        count_nxt = count_o - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // A match is a count step landing on a compare value
  assign m1_hit = step && (count_nxt == cmp_w[0]);
  assign m2_hit = step && (count_nxt == cmp_w[1]);

  assign copy[0] = sel_hit(sel1_r, m1_hit, m2_hit);
  assign copy[1] = sel_hit(sel2_r, m1_hit, m2_hit);

  // Two compare/preload slots
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_slot
      tcsc_cmp_slot #(
        .WIDTH (WIDTH)
      ) u_slot (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .wdata_i  (wdata_i),
        .cmp_we_i (cmp_we[g]),
        .pld_we_i (pld_we[g]),
        .copy_i   (copy[g]),
        .cmp_o    (cmp_w[g]),
        .pld_o    (pld_w[g])
      );
    end
  endgenerate

  // Counter, state and match pulses
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      count_o     <= `TCSC_RST_WORD;
      match_one_o <= 1'b0;
      match_two_o <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      count_o     <= count_nxt;
      match_one_o <= m1_hit;
      match_two_o <= m2_hit;
    end
  end

  // Last count direction; held while not counting in quadrature mode
  always @(posedge mclk_i) begin
    if (rst_i) begin
      up_last_r <= 1'b0;
    end else if (quad_mode && step) begin
      up_last_r <= cnt_up_i ^ dir_inv_r;
    end
  end

  // Mode, invert and load registers
  always @(posedge mclk_i) begin
    if (rst_i) begin
      mode_r    <= `TCSC_RST_MODE;
      dir_inv_r <= 1'b0;
      load_r    <= `TCSC_RST_WORD;
    end else begin
      if (wr_mode) begin
        mode_r    <= wdata_i[`TCSC_MODE_HI:`TCSC_MODE_LO];
        dir_inv_r <= wdata_i[`TCSC_BIT_DIR_INV];
      end
      if (wr_load) begin
        load_r <= wdata_i;
      end
    end
  end

  // Writable control fields of the status and control word
  always @(posedge mclk_i) begin
    if (rst_i) begin
      reinit_r <= 1'b0;
      m1_en_r  <= 1'b0;
      m2_en_r  <= 1'b0;
      sel1_r   <= `TCSC_SEL_NEVER;
      sel2_r   <= `TCSC_SEL_NEVER;
    end else if (wr_cs) begin
      reinit_r <= wdata_i[`TCSC_BIT_REINIT];
      m2_en_r  <= wdata_i[`TCSC_BIT_M2_EN];
      m1_en_r  <= wdata_i[`TCSC_BIT_M1_EN];
      sel2_r   <= wdata_i[`TCSC_SEL2_HI:`TCSC_SEL2_LO];
      sel1_r   <= wdata_i[`TCSC_SEL1_HI:`TCSC_SEL1_LO];
    end
  end

  // Sticky match flags; a match in the clearing cycle keeps the flag set
  always @(posedge mclk_i) begin
    if (rst_i) begin
      m1_flag_r <= 1'b0;
      m2_flag_r <= 1'b0;
    end else begin
      m1_flag_r <= m1_hit | (m1_flag_r & ~(wr_cs & ~wdata_i[`TCSC_BIT_M1_FLAG]));
      m2_flag_r <= m2_hit | (m2_flag_r & ~(wr_cs & ~wdata_i[`TCSC_BIT_M2_FLAG]));
    end
  end

  // Event status: sticky, cleared by reading it, set wins over the read
  assign evt_set[`TCSC_EVT_M1]     = m1_hit;
  assign evt_set[`TCSC_EVT_M2]     = m2_hit;
  assign evt_set[`TCSC_EVT_RELOAD] = reload;
  assign evt_set[`TCSC_EVT_PAUSE]  = pause;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      evt_stat_r <= `TCSC_RST_EVT;
      evt_mask_r <= `TCSC_RST_EVT;
    end else begin
      evt_stat_r <= evt_set | (rd_stat ? 4'h0 : evt_stat_r);
      if (wr_mask) begin
        evt_mask_r <= wdata_i[3:0];
      end
    end
  end

  // Interrupt level, registered so the pin has no decode glitches
  always @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (m2_en_r & m2_flag_r)
             | (m1_en_r & m1_flag_r)
             | (|(evt_stat_r & evt_mask_r));
    end
  end

  // Status and control word; bit 8 and the upper bits are held at zero
  assign cs_word = {{(WIDTH-11){1'b0}},
                    reinit_r,
                    up_last_r,
                    1'b0,
                    m2_en_r,
                    m1_en_r,
                    m2_flag_r,
                    m1_flag_r,
                    sel2_r,
                    sel1_r};

  // Read multiplexer; unmapped addresses read as zero
  always @* begin
    rd_val = {WIDTH{1'b0}};
    if (addr_i == `TCSC_OFF_CMP1) begin
      rd_val = cmp_w[0];
    end else if (addr_i == `TCSC_OFF_CMP2) begin
      rd_val = cmp_w[1];
    end else if (addr_i == `TCSC_OFF_PLD1) begin
      rd_val = pld_w[0];
    end else if (addr_i == `TCSC_OFF_PLD2) begin
      rd_val = pld_w[1];
    end else if (addr_i == `TCSC_OFF_MODE) begin
      rd_val = {{(WIDTH-4){1'b0}}, dir_inv_r, mode_r};
    end else if (addr_i == `TCSC_OFF_COUNT) begin
      rd_val = count_o;
    end else if (addr_i == `TCSC_OFF_EVT_STAT) begin
      rd_val = {{(WIDTH-4){1'b0}}, evt_stat_r};
    end else if (addr_i == `TCSC_OFF_EVT_MASK) begin
      rd_val = {{(WIDTH-4){1'b0}}, evt_mask_r};
    end else if (addr_i == `TCSC_OFF_LOAD) begin
      rd_val = load_r;
    end else if (addr_i == `TCSC_OFF_CSCTRL) begin
      rd_val = cs_word;
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= `TCSC_RST_WORD;
    end else if (rd_i) begin
      rdata_o <= rd_val;
    end else begin
      rdata_o <= `TCSC_RST_WORD;
    end
  end

endmodule // tcsc_top

// ---- testbench/tcsc_props.sv ----
// Port-level checks of the timer compare status and control block.
// Assumes one clock and a synchronous active-high reset; bound to tcsc_top.
`timescale 1ns/10ps
`include "tcsc_map.vh"

module tcsc_props #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire             mclk_i,
  input wire             rst_i,
  // Register port
  input wire [3:0]       addr_i,
  input wire [WIDTH-1:0] wdata_i,
  input wire             wr_i,
  input wire             rd_i,
  input wire [WIDTH-1:0] rdata_o,
  // Channel side
  input wire             cnt_up_i,
  input wire             cnt_dn_i,
  input wire             trig_i,
  input wire [WIDTH-1:0] count_o,
  input wire             match_one_o,
  input wire             match_two_o,
  input wire             irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Read data only in the slot after a read strobe
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
  a_rsvd_zero: assert property ($past(rd_i && addr_i == `TCSC_OFF_CSCTRL) |-> !rdata_o[8])
    else $error("reserved bit reads one");
  // A match is always the result of a single step
  a_m1_step: assert property (match_one_o |-> $past(cnt_up_i ^ cnt_dn_i))
    else $error("match one without step");
  a_m2_step: assert property (match_two_o |-> $past(cnt_up_i ^ cnt_dn_i))
    else $error("match two without step");
  // Without a step or trigger the counter holds
  a_count_hold: assert property (!(cnt_up_i ^ cnt_dn_i) && !trig_i |=> $stable(count_o))
    else $error("counter moved without cause");
  // Only a retrigger reload may move the counter by more than one
  a_count_jump: assert property (!$stable(count_o) |-> $past(trig_i)
    || count_o == $past(count_o) + 1'b1 || count_o == $past(count_o) - 1'b1)
    else $error("counter jumped without trigger");
  // Interrupt rises only after a flag, an enable write or a status event
  a_irq_rise: assert property ($rose(irq_o) |->
    $past(match_one_o | match_two_o) || $past(wr_i | trig_i, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wr_i | rd_i, 2))
    else $error("interrupt fell without clear");

  c_match_one: cover property (match_one_o);
  c_match_two: cover property (match_two_o);
  c_irq_rise: cover property ($rose(irq_o));
  c_count_reload: cover property ($past(trig_i) && !$stable(count_o));
endmodule // tcsc_props

bind tcsc_top tcsc_props #(.WIDTH(WIDTH)) u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cnt_up_i(cnt_up_i), .cnt_dn_i(cnt_dn_i), .trig_i(trig_i), .count_o(count_o),
  .match_one_o(match_one_o), .match_two_o(match_two_o), .irq_o(irq_o)
);

// ---- testbench/test_timer_compare_status_control.sv ----
// Self-checking bench of the timer compare status and control block.
// Assumes tcsc_top with 16-bit words and the map of tcsc_map.vh.
`timescale 1ns/10ps
`include "tcsc_map.vh"

module test_timer_compare_status_control;
  localparam [3:0] CS = `TCSC_OFF_CSCTRL;
  reg         mclk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [3:0]  addr_i = 4'h0;
  reg  [15:0] wdata_i = 16'h0000;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         cnt_up_i = 1'b0;
  reg         cnt_dn_i = 1'b0;
  reg         trig_i = 1'b0;
  wire [15:0] rdata_o;
  wire [15:0] count_o;
  wire        match_one_o;
  wire        match_two_o;
  wire        irq_o;
  integer     err_total = 0;
  integer     total_checks = 0;
  integer     seed = 32'h5910d9ed;
  integer     i;
  integer     s;
  integer     k;
  reg  [15:0] cnt = 16'h0000;
  reg  [15:0] pv = 16'h0000;
  reg  [15:0] c1;
  reg  [15:0] c2;
  reg         u;
  reg         d;
  reg  [31:0] rnd;

  always #4 mclk_i = ~mclk_i;

  tcsc_top #(.WIDTH(16)) u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .cnt_up_i(cnt_up_i), .cnt_dn_i(cnt_dn_i), .trig_i(trig_i), .count_o(count_o),
    .match_one_o(match_one_o), .match_two_o(match_two_o), .irq_o(irq_o)
  );

  // Compare and count one result
  task chk(input [15:0] got, input [15:0] exp, input [63:0] what);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: %0s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
    end
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input [3:0] a, input [15:0] exp, input [15:0] m);
    begin
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o & m, exp & m, "read");
    end
  endtask

  // One channel cycle; returns once the outputs of that edge settled
  task ev(input uu, input dd, input tt);
    begin
      @(posedge mclk_i);
      cnt_up_i <= uu;
      cnt_dn_i <= dd;
      trig_i <= tt;
      @(posedge mclk_i);
      cnt_up_i <= 1'b0;
      cnt_dn_i <= 1'b0;
      trig_i <= 1'b0;
      #1;
    end
  endtask

  // Irq is registered one edge behind its cause
  task irq_is(input v);
    begin
      @(posedge mclk_i);
      #1;
      chk({15'h0000, irq_o}, {15'h0000, v}, "irq");
    end
  endtask

  // Copy expected when the select names the compare that matched
  function loads(input [1:0] sel, input integer which);
    loads = (sel == 2'b01 && which == 0) || (sel == 2'b10 && which == 1);
  endfunction

  task end_sim;
    begin
      $display("Checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total = err_total + 1;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset value, unmapped place, reserved and read-only bits
    rd(CS, 16'h0000, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000, 16'hFFFF);
    wr(CS, 16'hFFFF);
    rd(CS, 16'h04CF, 16'hFFFF);
    wr(CS, 16'h0000);
    wr(`TCSC_OFF_CMP1, 16'h8000);
    wr(`TCSC_OFF_CMP2, 16'h8000);
    // Random quadrature steps, plain then inverted sense
    for (s = 0; s < 2; s = s + 1) begin
      wr(`TCSC_OFF_MODE, s ? 16'h000C : 16'h0004);
      for (i = 0; i < 16; i = i + 1) begin
        rnd = $random(seed);
        u = rnd[0];
        d = (i == 0) ? 1'b1 : rnd[1];
        ev(u, d, 1'b0);
        if (u ^ d) begin
          cnt = u ? cnt + 16'h0001 : cnt - 16'h0001;
          pv = {6'h00, u ^ s[0], 9'h000};
        end
        chk(count_o, cnt, "count");
        rd(CS, pv, 16'h0200);
      end
    end
    // Sticky flags, enables as masks, clearing by zero
    wr(`TCSC_OFF_MODE, 16'h0004);
    wr(`TCSC_OFF_CMP1, cnt + 16'h0001);
    wr(`TCSC_OFF_CMP2, cnt + 16'h0002);
    ev(1'b1, 1'b0, 1'b0);
    chk({15'h0000, match_one_o}, 16'h0001, "match1");
    ev(1'b1, 1'b0, 1'b0);
    chk({15'h0000, match_two_o}, 16'h0001, "match2");
    cnt = cnt + 16'h0002;
    irq_is(1'b0);
    rd(CS, 16'h0030, 16'h0030);
    wr(CS, 16'h0070);
    irq_is(1'b1);
    wr(CS, 16'h00A0);
    irq_is(1'b1);
    rd(CS, 16'h0020, 16'h0030);
    wr(CS, 16'h0080);
    irq_is(1'b0);
    // Match and clearing write at the same edge
    wr(`TCSC_OFF_CMP1, cnt + 16'h0001);
    @(posedge mclk_i);
    cnt_up_i <= 1'b1;
    addr_i <= CS;
    wdata_i <= 16'h0000;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    cnt_up_i <= 1'b0;
    wr_i <= 1'b0;
    cnt = cnt + 16'h0001;
    rd(CS, 16'h0010, 16'h0030);
    // Every preload select against either match
    for (s = 0; s < 4; s = s + 1) begin
      for (k = 0; k < 2; k = k + 1) begin
        rnd = $random(seed);
        pv = rnd[15:0];
        c1 = k ? 16'h8000 : cnt + 16'h0001;
        c2 = k ? cnt + 16'h0001 : 16'h8000;
        wr(`TCSC_OFF_CMP1, c1);
        wr(`TCSC_OFF_CMP2, c2);
        wr(`TCSC_OFF_PLD1, pv);
        wr(`TCSC_OFF_PLD2, ~pv);
        wr(CS, {12'h000, s[1:0], s[1:0]});
        ev(1'b1, 1'b0, 1'b0);
        cnt = cnt + 16'h0001;
        rd(`TCSC_OFF_CMP1, loads(s[1:0], k) ? pv : c1, 16'hFFFF);
        rd(`TCSC_OFF_CMP2, loads(s[1:0], k) ? ~pv : c2, 16'hFFFF);
        rd(`TCSC_OFF_PLD2, ~pv, 16'hFFFF);
      end
    end
    // Triggered mode: pause and resume, then reload
    wr(`TCSC_OFF_CMP1, 16'h8000);
    wr(`TCSC_OFF_CMP2, 16'h8000);
    rnd = $random(seed);
    pv = {4'h1, rnd[11:0]};
    wr(`TCSC_OFF_LOAD, pv);
    wr(CS, 16'h0000);
    wr(`TCSC_OFF_MODE, 16'h0006);
    ev(1'b1, 1'b0, 1'b0);
    chk(count_o, cnt, "idle");
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    cnt = cnt + 16'h0001;
    chk(count_o, cnt, "run");
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    chk(count_o, cnt, "pause");
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    cnt = cnt + 16'h0001;
    chk(count_o, cnt, "resume");
    wr(CS, 16'h0400);
    ev(1'b0, 1'b0, 1'b1);
    chk(count_o, pv, "reload");
    ev(1'b1, 1'b0, 1'b0);
    chk(count_o, pv + 16'h0001, "goes on");
    // Event status: every event sticky, a read clears it, the mask gates irq
    rd(`TCSC_OFF_EVT_STAT, 16'h000F, 16'hFFFF);
    rd(`TCSC_OFF_EVT_STAT, 16'h0000, 16'hFFFF);
    wr(`TCSC_OFF_EVT_MASK, 16'h0004);
    ev(1'b0, 1'b0, 1'b1);
    chk(count_o, pv, "reload2");
    irq_is(1'b1);
    rd(`TCSC_OFF_EVT_STAT, 16'h0004, 16'hFFFF);
    irq_is(1'b0);
    end_sim;
  end
endmodule // test_timer_compare_status_control
